// ==== verilog/lpmc_pkg.sv ====
package lpmc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_PROTECT = 8'h00;
	localparam logic [7:0] OFS_STBY_CTRL = 8'h04;
	localparam logic [7:0] OFS_MSTOP_A = 8'h08;
	localparam logic [7:0] OFS_MSTOP_B = 8'h0c;
	localparam logic [7:0] OFS_MSTOP_C = 8'h10;
	localparam logic [7:0] OFS_MSTOP_D = 8'h14;
	localparam logic [7:0] OFS_DEEP_CTRL = 8'h18;
	localparam logic [7:0] OFS_WAKE_EN = 8'h1c;
	localparam logic [7:0] OFS_WAKE_FLAG = 8'h20;
	localparam logic [7:0] OFS_MODE = 8'h24;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h2c;
	localparam logic [7:0] OFS_IRQ_EN = 8'h30;
	// Protection register
	localparam logic [7:0] PROT_KEY = 8'ha5;
	localparam int PROT_CLK_BIT = 0;
	localparam int PROT_PWR_BIT = 1;
	// Field positions
	localparam int STBY_SEL_BIT = 15;
	localparam int BUS_OE_BIT = 14;
	localparam int ALL_STOP_BIT = 31;
	localparam int TIMER_PAIR_BIT = 5;
	localparam int DEEP_EN_BIT = 7;
	localparam int IO_RET_BIT = 6;
	localparam int CUT_HI = 1;
	localparam int CUT_LO = 0;
	localparam int PIN11_BIT = 3;
	localparam int IRQ_PIN_BIT = 0;
	localparam int IRQ_WAKE_BIT = 1;
	localparam int IRQ_DEEP_BIT = 2;
	localparam logic [1:0] CUT_RAM_USB = 2'h1;
	// Reset values
	localparam logic [15:0] PROTECT_RST = 16'h0000;
	localparam logic [15:0] STBY_CTRL_RST = 16'h4000;
	localparam logic [31:0] MSTOP_A_RST = 32'hffff_ffff;
	localparam logic [31:0] MSTOP_B_RST = 32'hffff_ffff;
	localparam logic [31:0] MSTOP_C_RST = 32'hffff_0000;
	localparam logic [31:0] MSTOP_D_RST = 32'hffff_ffff;
	localparam logic [7:0] DEEP_CTRL_RST = 8'h00;
	localparam logic [7:0] WAKE_RST = 8'h00;
	localparam logic [2:0] IRQ_RST = 3'h0;
	// Restart hold after deep standby cancel
	localparam int CLK_HZ = 25000000;
	localparam int RESTART_NS = 1000;
	localparam int RESTART_CYC = (RESTART_NS * (CLK_HZ / 1000000)) / 1000;
	localparam logic [7:0] RESTART_LOAD = 8'(RESTART_CYC - 1);
	// Operating modes
	typedef enum logic [2:0] {
		LPMC_RUN = 3'h0,
		LPMC_SLEEP = 3'h1,
		LPMC_ALLSTOP = 3'h2,
		LPMC_SWSTBY = 3'h3,
		LPMC_DEEP = 3'h4,
		LPMC_RESTART = 3'h5
	} lpmc_mode_t;
endpackage : lpmc_pkg

// ==== verilog/lpmc_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpmc_sync3 (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pin and filtered level
	input wire logic pin_i,
	output logic level_o
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
		end else begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Change taken only once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_ff <= 1'b1;
		end else if (s2_ff == s3_ff) begin
			level_ff <= s3_ff;
		end
	end

	assign level_o = level_ff;
endmodule : lpmc_sync3
`default_nettype wire

// ==== verilog/lpmc_top.sv ====
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Key write A503h unlocks clock and power protected registers.
// - Key write A500h relocks; protected writes then change nothing.
// - Power registers accept writes only while power unlock bit is 1.
// - Wait with standby select 0 enters sleep; CPU halted, peripherals run.
// - Wait with standby select 1 enters software standby.
// - Bus output enable 0 floats external bus in standby modes.
// - All-clock-stop enable with sleep entry gives all-module clock stop.
// - Module stop A bit 5 clear keeps timer pair clocked.
// - Module stop C lower half zero keeps RAM clocked.
// - Deep enable and standby select enter deep standby on wait.
// - Deep enable 0 with standby select 1 gives ordinary software standby.
// - Power cut field 01b removes RAM and USB resume power.
// - Retention 0 releases held I/O when deep standby cancels.
// - Pin 11 wake enable accepts the pin as deep standby cancel.
// - Pin 11 request sets wake flag; software clears it writing 0.
module lpmc_top (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// CPU side
	input wire logic WAIT_I,
	input wire logic WAKE_I,
	output logic CPU_HALT_O,
	output logic SYS_RST_O,
	// Pin wake source, active low
	input wire logic EXT_IRQ_PIN_11_I,
	// Power and clock controls
	output logic [31:0] MOD_CLK_EN_A_O,
	output logic [31:0] MOD_CLK_EN_B_O,
	output logic [31:0] MOD_CLK_EN_C_O,
	output logic [31:0] MOD_CLK_EN_D_O,
	output logic SYS_PCLK_EN_O,
	output logic BUS_HIZ_O,
	output logic RAM_PWR_OFF_O,
	output logic IO_HOLD_O,
	output logic [2:0] MODE_O,
	// Interrupt
	output logic IRQ_O
);
	lpmc_pkg::lpmc_mode_t state_ff;
	lpmc_pkg::lpmc_mode_t nxt_state;
	logic [15:0] write_protect_reg_ff;
	logic [15:0] standby_control_reg_ff;
	logic [31:0] mstop_ff [4];
	logic [7:0] deep_standby_control_reg_ff;
	logic [7:0] deep_wake_enable_reg_ff;
	logic [7:0] deep_wake_flag_reg_ff;
	logic [2:0] irq_stat_ff;
	logic [2:0] irq_en_ff;
	logic [7:0] restart_cnt_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] clk_en_ff [4];
	logic pclk_en_ff;
	logic bus_hiz_ff;
	logic ram_off_ff;
	logic io_hold_ff;
	logic halt_ff;
	logic sys_rst_ff;
	logic irq_ff;
	logic pin_lvl;
	logic pin_lvl_d_ff;
	logic pin_req;
	logic wr_en;
	logic pwr_open;
	logic prot_key_ok;
	logic deep_cancel;
	logic wake_exit;
	logic restart_start;
	logic [31:0] rd_mux;
	logic rd_err;

	lpmc_sync3 u_pin_sync (
		.clk_i(CORE_CLK_I),
		.rst_i(RST_I),
		.pin_i(EXT_IRQ_PIN_11_I),
		.level_o(pin_lvl)
	);

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			pin_lvl_d_ff <= 1'b1;
		end else begin
			pin_lvl_d_ff <= pin_lvl;
		end
	end

	// Falling edge of the filtered pin is a wake request
	assign pin_req = pin_lvl_d_ff & ~pin_lvl;
	assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & pready_ff;
	assign prot_key_ok = PWDATA_I[15:8] == lpmc_pkg::PROT_KEY;
	assign pwr_open = write_protect_reg_ff[lpmc_pkg::PROT_PWR_BIT];
	assign deep_cancel = (state_ff == lpmc_pkg::LPMC_DEEP) &&
		(deep_wake_flag_reg_ff[lpmc_pkg::PIN11_BIT] &
		deep_wake_enable_reg_ff[lpmc_pkg::PIN11_BIT]);
	assign wake_exit = WAKE_I && (state_ff == lpmc_pkg::LPMC_SLEEP ||
		state_ff == lpmc_pkg::LPMC_ALLSTOP || state_ff == lpmc_pkg::LPMC_SWSTBY);
	assign restart_start = deep_cancel;

	// Mode sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			lpmc_pkg::LPMC_RUN: begin
				if (WAIT_I) begin
					if (!standby_control_reg_ff[lpmc_pkg::STBY_SEL_BIT]) begin
						nxt_state = mstop_ff[0][lpmc_pkg::ALL_STOP_BIT] ?
							lpmc_pkg::LPMC_ALLSTOP : lpmc_pkg::LPMC_SLEEP;
					end else begin
						nxt_state = deep_standby_control_reg_ff[lpmc_pkg::DEEP_EN_BIT] ?
							lpmc_pkg::LPMC_DEEP : lpmc_pkg::LPMC_SWSTBY;
					end
				end
			end
			lpmc_pkg::LPMC_SLEEP, lpmc_pkg::LPMC_ALLSTOP, lpmc_pkg::LPMC_SWSTBY: begin
				if (wake_exit) begin
					nxt_state = lpmc_pkg::LPMC_RUN;
				end
			end
			lpmc_pkg::LPMC_DEEP: begin
				if (deep_cancel) begin
					nxt_state = lpmc_pkg::LPMC_RESTART;
				end
			end
			lpmc_pkg::LPMC_RESTART: begin
				if (restart_cnt_ff == 8'h00) begin
					nxt_state = lpmc_pkg::LPMC_RUN;
				end
			end
			default: begin
				nxt_state = lpmc_pkg::LPMC_RUN;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			state_ff <= lpmc_pkg::LPMC_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			restart_cnt_ff <= 8'h00;
		end else if (restart_start) begin
			restart_cnt_ff <= lpmc_pkg::RESTART_LOAD;
		end else if (restart_cnt_ff != 8'h00) begin
			restart_cnt_ff <= restart_cnt_ff - 8'h01;
		end
	end

	// Protection register; deep cancel reset relocks it
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I || restart_start) begin
			write_protect_reg_ff <= lpmc_pkg::PROTECT_RST;
		end else if (wr_en && PADDR_I == lpmc_pkg::OFS_PROTECT && prot_key_ok) begin
			write_protect_reg_ff <= {8'h00, 6'h00, PWDATA_I[1:0]};
		end
	end

	// Protected power-mode registers
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I || restart_start) begin
			standby_control_reg_ff <= lpmc_pkg::STBY_CTRL_RST;
			mstop_ff[0] <= lpmc_pkg::MSTOP_A_RST;
			mstop_ff[1] <= lpmc_pkg::MSTOP_B_RST;
			mstop_ff[2] <= lpmc_pkg::MSTOP_C_RST;
			mstop_ff[3] <= lpmc_pkg::MSTOP_D_RST;
		end else if (wr_en && pwr_open) begin
			if (PADDR_I == lpmc_pkg::OFS_STBY_CTRL) begin
				standby_control_reg_ff <= PWDATA_I[15:0];
			end else if (PADDR_I == lpmc_pkg::OFS_MSTOP_A) begin
				mstop_ff[0] <= PWDATA_I;
			end else if (PADDR_I == lpmc_pkg::OFS_MSTOP_B) begin
				mstop_ff[1] <= PWDATA_I;
			end else if (PADDR_I == lpmc_pkg::OFS_MSTOP_C) begin
				mstop_ff[2] <= PWDATA_I;
			end else if (PADDR_I == lpmc_pkg::OFS_MSTOP_D) begin
				mstop_ff[3] <= PWDATA_I;
			end
		end
	end

	// Deep standby settings survive the cancel reset
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			deep_standby_control_reg_ff <= lpmc_pkg::DEEP_CTRL_RST;
			deep_wake_enable_reg_ff <= lpmc_pkg::WAKE_RST;
		end else if (wr_en && pwr_open) begin
			if (PADDR_I == lpmc_pkg::OFS_DEEP_CTRL) begin
				deep_standby_control_reg_ff <= PWDATA_I[7:0];
			end else if (PADDR_I == lpmc_pkg::OFS_WAKE_EN) begin
				deep_wake_enable_reg_ff <= PWDATA_I[7:0];
			end
		end
	end

	// Wake flags: only zeros written clear, a new request wins
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			deep_wake_flag_reg_ff <= lpmc_pkg::WAKE_RST;
		end else begin
			deep_wake_flag_reg_ff[lpmc_pkg::PIN11_BIT] <= pin_req |
				(deep_wake_flag_reg_ff[lpmc_pkg::PIN11_BIT] &
				~(wr_en && pwr_open && PADDR_I == lpmc_pkg::OFS_WAKE_FLAG &&
				!PWDATA_I[lpmc_pkg::PIN11_BIT]));
		end
	end

	// Interrupt status, clear and enable
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			irq_stat_ff <= lpmc_pkg::IRQ_RST;
		end else begin
			irq_stat_ff <= {restart_start, wake_exit, pin_req} |
				(irq_stat_ff & ~((wr_en && PADDR_I == lpmc_pkg::OFS_IRQ_CLR) ?
				PWDATA_I[2:0] : 3'h0));
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			irq_en_ff <= lpmc_pkg::IRQ_RST;
			irq_ff <= 1'b0;
		end else begin
			if (wr_en && PADDR_I == lpmc_pkg::OFS_IRQ_EN) begin
				irq_en_ff <= PWDATA_I[2:0];
			end
			irq_ff <= |(irq_stat_ff & irq_en_ff);
		end
	end

	// Read decode
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		if (PADDR_I == lpmc_pkg::OFS_PROTECT) begin
			rd_mux = {16'h0000, write_protect_reg_ff};
		end else if (PADDR_I == lpmc_pkg::OFS_STBY_CTRL) begin
			rd_mux = {16'h0000, standby_control_reg_ff};
		end else if (PADDR_I == lpmc_pkg::OFS_MSTOP_A) begin
			rd_mux = mstop_ff[0];
		end else if (PADDR_I == lpmc_pkg::OFS_MSTOP_B) begin
			rd_mux = mstop_ff[1];
		end else if (PADDR_I == lpmc_pkg::OFS_MSTOP_C) begin
			rd_mux = mstop_ff[2];
		end else if (PADDR_I == lpmc_pkg::OFS_MSTOP_D) begin
			rd_mux = mstop_ff[3];
		end else if (PADDR_I == lpmc_pkg::OFS_DEEP_CTRL) begin
			rd_mux = {24'h00_0000, deep_standby_control_reg_ff};
		end else if (PADDR_I == lpmc_pkg::OFS_WAKE_EN) begin
			rd_mux = {24'h00_0000, deep_wake_enable_reg_ff};
		end else if (PADDR_I == lpmc_pkg::OFS_WAKE_FLAG) begin
			rd_mux = {24'h00_0000, deep_wake_flag_reg_ff};
		end else if (PADDR_I == lpmc_pkg::OFS_MODE) begin
			rd_mux = {29'h0000_0000, state_ff};
		end else if (PADDR_I == lpmc_pkg::OFS_IRQ_STAT) begin
			rd_mux = {29'h0000_0000, irq_stat_ff};
		end else if (PADDR_I == lpmc_pkg::OFS_IRQ_CLR) begin
			rd_mux = 32'h0000_0000;
		end else if (PADDR_I == lpmc_pkg::OFS_IRQ_EN) begin
			rd_mux = {29'h0000_0000, irq_en_ff};
		end else begin
			rd_err = 1'b1;
		end
	end

	// Answer prepared in setup so that every output is a flop
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= PSEL_I & ~PENABLE_I;
			pslverr_ff <= PSEL_I & ~PENABLE_I & rd_err;
			prdata_ff <= (PSEL_I & ~PENABLE_I & ~PWRITE_I) ? rd_mux : 32'h0000_0000;
		end
	end

	// Clock, bus and power controls
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			for (int i = 0; i < 4; i++) begin
				clk_en_ff[i] <= 32'h0000_0000;
			end
			pclk_en_ff <= 1'b1;
			bus_hiz_ff <= 1'b0;
			ram_off_ff <= 1'b0;
			halt_ff <= 1'b0;
			sys_rst_ff <= 1'b0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				clk_en_ff[i] <= (state_ff == lpmc_pkg::LPMC_SWSTBY ||
					state_ff == lpmc_pkg::LPMC_DEEP) ? 32'h0000_0000 : ~mstop_ff[i];
			end
			// Shared peripheral clock stops in all-stop
			pclk_en_ff <= state_ff == lpmc_pkg::LPMC_RUN || state_ff == lpmc_pkg::LPMC_SLEEP;
			bus_hiz_ff <= !standby_control_reg_ff[lpmc_pkg::BUS_OE_BIT] &&
				(state_ff == lpmc_pkg::LPMC_ALLSTOP || state_ff == lpmc_pkg::LPMC_SWSTBY ||
				state_ff == lpmc_pkg::LPMC_DEEP);
			ram_off_ff <= state_ff == lpmc_pkg::LPMC_DEEP && deep_standby_control_reg_ff
				[lpmc_pkg::CUT_HI:lpmc_pkg::CUT_LO] == lpmc_pkg::CUT_RAM_USB;
			halt_ff <= state_ff != lpmc_pkg::LPMC_RUN;
			sys_rst_ff <= state_ff == lpmc_pkg::LPMC_RESTART;
		end
	end

	// Held I/O; with retention set, software releases it later
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			io_hold_ff <= 1'b0;
		end else begin
			io_hold_ff <= state_ff == lpmc_pkg::LPMC_DEEP ||
				(io_hold_ff && deep_standby_control_reg_ff[lpmc_pkg::IO_RET_BIT]);
		end
	end

	assign PRDATA_O = prdata_ff;
	assign PREADY_O = pready_ff;
	assign PSLVERR_O = pslverr_ff;
	assign CPU_HALT_O = halt_ff;
	assign SYS_RST_O = sys_rst_ff;
	assign MOD_CLK_EN_A_O = clk_en_ff[0];
	assign MOD_CLK_EN_B_O = clk_en_ff[1];
	assign MOD_CLK_EN_C_O = clk_en_ff[2];
	assign MOD_CLK_EN_D_O = clk_en_ff[3];
	assign SYS_PCLK_EN_O = pclk_en_ff;
	assign BUS_HIZ_O = bus_hiz_ff;
	assign RAM_PWR_OFF_O = ram_off_ff;
	assign IO_HOLD_O = io_hold_ff;
	assign MODE_O = state_ff;
	assign IRQ_O = irq_ff;

	unlock_key_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		wr_en && PADDR_I == lpmc_pkg::OFS_PROTECT &&
		PWDATA_I[15:0] == {lpmc_pkg::PROT_KEY, 8'h03} && !restart_start
		|=> write_protect_reg_ff[1:0] == 2'h3)
		else $error("unlock value did not open both protections");
	relock_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		!pwr_open && !restart_start |=> $stable(standby_control_reg_ff) && $stable(mstop_ff[0]))
		else $error("locked power register changed");
	key_check_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		wr_en && PADDR_I == lpmc_pkg::OFS_PROTECT && !prot_key_ok && !restart_start
		|=> $stable(write_protect_reg_ff))
		else $error("protection changed without key");
	sleep_entry_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		state_ff == lpmc_pkg::LPMC_RUN && WAIT_I &&
		!standby_control_reg_ff[lpmc_pkg::STBY_SEL_BIT] &&
		!mstop_ff[0][lpmc_pkg::ALL_STOP_BIT]
		|=> state_ff == lpmc_pkg::LPMC_SLEEP ##1 halt_ff && pclk_en_ff)
		else $error("sleep entry wrong");
	standby_sel_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		state_ff == lpmc_pkg::LPMC_RUN && WAIT_I &&
		standby_control_reg_ff[lpmc_pkg::STBY_SEL_BIT] &&
		!deep_standby_control_reg_ff[lpmc_pkg::DEEP_EN_BIT]
		|=> state_ff == lpmc_pkg::LPMC_SWSTBY)
		else $error("standby entry wrong");
	deep_entry_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		state_ff == lpmc_pkg::LPMC_RUN && WAIT_I &&
		standby_control_reg_ff[lpmc_pkg::STBY_SEL_BIT] &&
		deep_standby_control_reg_ff[lpmc_pkg::DEEP_EN_BIT]
		|=> state_ff == lpmc_pkg::LPMC_DEEP)
		else $error("deep entry wrong");
	allstop_entry_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		state_ff == lpmc_pkg::LPMC_RUN && WAIT_I &&
		!standby_control_reg_ff[lpmc_pkg::STBY_SEL_BIT] &&
		mstop_ff[0][lpmc_pkg::ALL_STOP_BIT]
		|=> state_ff == lpmc_pkg::LPMC_ALLSTOP ##1 !pclk_en_ff)
		else $error("all-stop entry wrong");
	bus_float_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		state_ff == lpmc_pkg::LPMC_SWSTBY && !standby_control_reg_ff[lpmc_pkg::BUS_OE_BIT]
		|=> bus_hiz_ff)
		else $error("bus not floated in standby");
	power_cut_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		state_ff == lpmc_pkg::LPMC_DEEP && deep_standby_control_reg_ff
		[lpmc_pkg::CUT_HI:lpmc_pkg::CUT_LO] == lpmc_pkg::CUT_RAM_USB
		|=> ram_off_ff)
		else $error("power cut missing in deep standby");
	io_release_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		state_ff == lpmc_pkg::LPMC_DEEP && deep_cancel &&
		!deep_standby_control_reg_ff[lpmc_pkg::IO_RET_BIT]
		|=> ##1 !io_hold_ff)
		else $error("io hold not released on cancel");
	wake_flag_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		pin_req |=> deep_wake_flag_reg_ff[lpmc_pkg::PIN11_BIT])
		else $error("pin request lost");
	deep_cancel_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		deep_cancel |=> state_ff == lpmc_pkg::LPMC_RESTART ##1 sys_rst_ff ##[1:40]
		state_ff == lpmc_pkg::LPMC_RUN)
		else $error("deep cancel restart wrong");
endmodule : lpmc_top
`default_nettype wire

// ==== verif/lpmc_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk;
	logic rst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic wait_req;
	logic wake;
	logic pin11_n;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cpu_halt;
	logic sys_rst;
	logic [31:0] clk_en_a;
	logic [31:0] clk_en_b;
	logic [31:0] clk_en_c;
	logic [31:0] clk_en_d;
	logic pclk_en;
	logic bus_hiz;
	logic ram_off;
	logic io_hold;
	logic [2:0] mode;
	logic irq;
	int n_fail;
	int compares;
	logic [31:0] rdat;
	logic rerr;
	logic [31:0] mstop_rst [4];

	lpmc_top dut (
		.CORE_CLK_I(clk),
		.RST_I(rst),
		.PSEL_I(psel),
		.PENABLE_I(penable),
		.PWRITE_I(pwrite),
		.PADDR_I(paddr),
		.PWDATA_I(pwdata),
		.PRDATA_O(prdata),
		.PREADY_O(pready),
		.PSLVERR_O(pslverr),
		.WAIT_I(wait_req),
		.WAKE_I(wake),
		.CPU_HALT_O(cpu_halt),
		.SYS_RST_O(sys_rst),
		.EXT_IRQ_PIN_11_I(pin11_n),
		.MOD_CLK_EN_A_O(clk_en_a),
		.MOD_CLK_EN_B_O(clk_en_b),
		.MOD_CLK_EN_C_O(clk_en_c),
		.MOD_CLK_EN_D_O(clk_en_d),
		.SYS_PCLK_EN_O(pclk_en),
		.BUS_HIZ_O(bus_hiz),
		.RAM_PWR_OFF_O(ram_off),
		.IO_HOLD_O(io_hold),
		.MODE_O(mode),
		.IRQ_O(irq)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task finish_test;
		if (n_fail == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task chk1(input logic seen, input logic exp);
		chk({31'h0, seen}, {31'h0, exp});
	endtask : chk1

	task step(input int n);
		repeat (n) @(posedge clk);
	endtask : step

	// One APB transfer; request held until pready is seen high
	task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) n_fail++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask : rd

	task wait_mode(input logic [2:0] m, input int lim);
		int n;
		n = 0;
		while (mode !== m && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk({29'h0, mode}, {29'h0, m});
	endtask : wait_mode

	task enter(input logic [2:0] m);
		@(posedge clk);
		wait_req <= 1'b1;
		@(posedge clk);
		wait_req <= 1'b0;
		wait_mode(m, 5);
		step(2);
	endtask : enter

	task wake_up;
		@(posedge clk);
		wake <= 1'b1;
		wait_mode(lpmc_pkg::LPMC_RUN, 5);
		wake <= 1'b0;
	endtask : wake_up

	// Bounded run; a hang ends as a failure
	initial begin
		step(5000);
		n_fail++;
		finish_test();
	end

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		wait_req = 1'b0;
		wake = 1'b0;
		pin11_n = 1'b1;
		n_fail = 0;
		compares = 0;
		mstop_rst = '{lpmc_pkg::MSTOP_A_RST, lpmc_pkg::MSTOP_B_RST,
			lpmc_pkg::MSTOP_C_RST, lpmc_pkg::MSTOP_D_RST};
		step(2);
		rst <= 1'b0;
		step(6);
		rd(lpmc_pkg::OFS_STBY_CTRL, 32'h0000_4000);
		for (int i = 0; i < 4; i++) begin
			rd(lpmc_pkg::OFS_MSTOP_A + 8'(4 * i), mstop_rst[i]);
		end
		chk(clk_en_c, 32'h0000_ffff);
		wr(lpmc_pkg::OFS_MSTOP_A, 32'h0);
		rd(lpmc_pkg::OFS_MSTOP_A, 32'hffff_ffff);
		wr(lpmc_pkg::OFS_PROTECT, 32'h0000_5a03);
		wr(lpmc_pkg::OFS_MSTOP_A, 32'h0);
		rd(lpmc_pkg::OFS_MSTOP_A, 32'hffff_ffff);
		wr(lpmc_pkg::OFS_PROTECT, 32'h0000_a503);
		rd(lpmc_pkg::OFS_PROTECT, 32'h0000_0003);
		wr(lpmc_pkg::OFS_MSTOP_A, 32'h7fff_ffdf);
		rd(lpmc_pkg::OFS_MSTOP_A, 32'h7fff_ffdf);
		step(2);
		chk(clk_en_a, 32'h8000_0020);
		wr(lpmc_pkg::OFS_PROTECT, 32'h0000_a500);
		wr(lpmc_pkg::OFS_MSTOP_A, 32'h0);
		rd(lpmc_pkg::OFS_MSTOP_A, 32'h7fff_ffdf);
		apb(1'b0, 8'h3c, 32'h0);
		chk1(rerr, 1'b1);
		// Sleep keeps peripherals clocked and the bus driven
		wr(lpmc_pkg::OFS_PROTECT, 32'h0000_a503);
		wr(lpmc_pkg::OFS_STBY_CTRL, 32'h0);
		enter(lpmc_pkg::LPMC_SLEEP);
		chk1(cpu_halt, 1'b1);
		chk1(pclk_en, 1'b1);
		chk1(bus_hiz, 1'b0);
		wake_up();
		rd(lpmc_pkg::OFS_IRQ_STAT, 32'h2);
		wr(lpmc_pkg::OFS_IRQ_EN, 32'h2);
		step(2);
		chk1(irq, 1'b1);
		wr(lpmc_pkg::OFS_IRQ_EN, 32'h0);
		step(2);
		chk1(irq, 1'b0);
		wr(lpmc_pkg::OFS_IRQ_CLR, 32'h2);
		rd(lpmc_pkg::OFS_IRQ_STAT, 32'h0);
		// All-module stop with the timer pair left running
		wr(lpmc_pkg::OFS_MSTOP_A, 32'hffff_ffdf);
		enter(lpmc_pkg::LPMC_ALLSTOP);
		chk1(bus_hiz, 1'b1);
		chk(clk_en_a, 32'h0000_0020);
		chk(clk_en_c, 32'h0000_ffff);
		chk(clk_en_b, ~lpmc_pkg::MSTOP_B_RST);
		chk(clk_en_d, ~lpmc_pkg::MSTOP_D_RST);
		chk1(pclk_en, 1'b0);
		wake_up();
		// Standby with bus outputs kept, then floated
		wr(lpmc_pkg::OFS_STBY_CTRL, 32'h0000_c000);
		wr(lpmc_pkg::OFS_DEEP_CTRL, 32'h0);
		enter(lpmc_pkg::LPMC_SWSTBY);
		chk1(bus_hiz, 1'b0);
		chk(clk_en_a, 32'h0);
		wake_up();
		wr(lpmc_pkg::OFS_STBY_CTRL, 32'h0000_8000);
		enter(lpmc_pkg::LPMC_SWSTBY);
		chk1(bus_hiz, 1'b1);
		wake_up();
		// Deep standby, woken by the pin through a restart
		wr(lpmc_pkg::OFS_DEEP_CTRL, 32'h0000_0081);
		wr(lpmc_pkg::OFS_WAKE_EN, 32'h8);
		wr(lpmc_pkg::OFS_WAKE_FLAG, 32'h0);
		rd(lpmc_pkg::OFS_WAKE_FLAG, 32'h0);
		wr(lpmc_pkg::OFS_IRQ_CLR, 32'h7);
		wr(lpmc_pkg::OFS_PROTECT, 32'h0000_a500);
		enter(lpmc_pkg::LPMC_DEEP);
		chk1(ram_off, 1'b1);
		chk1(io_hold, 1'b1);
		rd(lpmc_pkg::OFS_MODE, {29'h0, lpmc_pkg::LPMC_DEEP});
		wake <= 1'b1;
		step(3);
		wake <= 1'b0;
		chk({29'h0, mode}, {29'h0, lpmc_pkg::LPMC_DEEP});
		pin11_n <= 1'b0;
		wait_mode(lpmc_pkg::LPMC_RESTART, 20);
		step(3);
		chk1(sys_rst, 1'b1);
		chk1(io_hold, 1'b0);
		pin11_n <= 1'b1;
		wait_mode(lpmc_pkg::LPMC_RUN, 40);
		rd(lpmc_pkg::OFS_WAKE_FLAG, 32'h8);
		rd(lpmc_pkg::OFS_STBY_CTRL, 32'h0000_4000);
		rd(lpmc_pkg::OFS_IRQ_STAT, 32'h5);
		wr(lpmc_pkg::OFS_PROTECT, 32'h0000_a503);
		wr(lpmc_pkg::OFS_WAKE_FLAG, 32'h8);
		rd(lpmc_pkg::OFS_WAKE_FLAG, 32'h8);
		wr(lpmc_pkg::OFS_WAKE_FLAG, 32'h0);
		rd(lpmc_pkg::OFS_WAKE_FLAG, 32'h0);
		finish_test();
	end
endmodule : tb
`default_nettype wire
